// ### bench/csr_core_regs_sva.sv
`timescale 1ns/1ps
module csr_core_regs_sva (
  input wire logic                 mclk_i,
  input wire logic                 sys_rst_i,
  input wire logic [7:0]           sfr_addr_i,
  input wire logic                 sfr_rd_i,
  input wire logic                 sfr_wr_i,
  input wire logic [7:0]           sfr_wdata_i,
  input wire logic                 bit_wr_i,
  input wire logic                 push_i,
  input wire logic [7:0]           push_data_i,
  input wire logic                 pop_i,
  input wire logic                 data_pointer_16_load_i,
  input wire logic                 data_pointer_16_inc_i,
  input wire csr_pkg::csr_alu_op_e alu_op_i,
  input wire logic [7:0]           sfr_rdata_o,
  input wire logic                 sfr_hit_o,
  input wire logic                 stack_wr_o,
  input wire logic                 stack_rd_o,
  input wire logic [7:0]           stack_addr_o,
  input wire logic [7:0]           stack_wdata_o,
  input wire logic [15:0]          data_pointer_16_o,
  input wire logic [7:0]           stack_top_pointer_o,
  input wire logic [7:0]           accumulator_o,
  input wire logic [7:0]           program_status_word_o,
  input wire logic [4:0]           bank_base_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_push_order: assert property (push_i |=> stack_wr_o
    && stack_addr_o == $past(stack_top_pointer_o) + 8'h01
    && stack_top_pointer_o == stack_addr_o && stack_wdata_o == $past(push_data_i))
    else $error("push order wrong");
  chk_pop_order: assert property (pop_i && !push_i |=> stack_rd_o
    && stack_addr_o == $past(stack_top_pointer_o)
    && stack_top_pointer_o == $past(stack_top_pointer_o) - 8'h01)
    else $error("pop order wrong");
  chk_reset_values: assert property ($fell(sys_rst_i) |->
    stack_top_pointer_o == 8'h07 && accumulator_o == 8'h00)
    else $error("reset values wrong");
  chk_parity_live: assert property (program_status_word_o[0] == ^accumulator_o)
    else $error("parity flag wrong");
  chk_bank_base: assert property (bank_base_o == {program_status_word_o[4:3], 3'h0})
    else $error("bank base wrong");
  chk_data_pointer_16_high: assert property (sfr_wr_i && sfr_addr_i == csr_pkg::ADDR_DPH
    && !data_pointer_16_load_i && !data_pointer_16_inc_i |=> data_pointer_16_o[15:8] == $past(sfr_wdata_i)
    && $stable(data_pointer_16_o[7:0]))
    else $error("pointer high byte wrong");
  chk_pointer_read: assert property (sfr_rd_i && sfr_addr_i == csr_pkg::ADDR_SP
    |=> sfr_hit_o && sfr_rdata_o == $past(stack_top_pointer_o))
    else $error("stack pointer read wrong");
  chk_user_flags: assert property (alu_op_i != csr_pkg::ALU_NONE
    && !sfr_wr_i && !bit_wr_i |=> $stable(program_status_word_o[5])
    && $stable(program_status_word_o[1]))
    else $error("user flag changed by arithmetic");
endmodule : csr_core_regs_sva

bind csr_core_regs csr_core_regs_sva csr_core_regs_sva_inst (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .bit_wr_i(bit_wr_i), .push_i(push_i),
  .push_data_i(push_data_i), .pop_i(pop_i), .data_pointer_16_load_i(data_pointer_16_load_i),
  .data_pointer_16_inc_i(data_pointer_16_inc_i), .alu_op_i(alu_op_i), .sfr_rdata_o(sfr_rdata_o),
  .sfr_hit_o(sfr_hit_o), .stack_wr_o(stack_wr_o), .stack_rd_o(stack_rd_o),
  .stack_addr_o(stack_addr_o), .stack_wdata_o(stack_wdata_o),
  .data_pointer_16_o(data_pointer_16_o), .stack_top_pointer_o(stack_top_pointer_o),
  .accumulator_o(accumulator_o), .program_status_word_o(program_status_word_o),
  .bank_base_o(bank_base_o));

// ### bench/csr_core_regs_tb.sv
`timescale 1ns/1ps
module csr_core_regs_tb;
  logic                 mclk_i, sys_rst_i, sfr_rd_i, sfr_wr_i, bit_rd_i, bit_wr_i;
  logic                 bit_wdata_i, push_i, pop_i, data_pointer_16_load_i, data_pointer_16_inc_i, acc_load_i;
  logic [7:0]           sfr_addr_i, sfr_wdata_i, bit_addr_i, push_data_i;
  logic [7:0]           acc_wdata_i, alu_operand_i, b_reg_i, d;
  logic [15:0]          data_pointer_16_wdata_i;
  csr_pkg::csr_alu_op_e alu_op_i;
  logic                 sfr_hit_o, bit_rdata_o, bit_hit_o, stack_wr_o, stack_rd_o, b_wr_o, h;
  logic [7:0]           sfr_rdata_o, stack_addr_o, stack_wdata_o, stack_top_pointer_o;
  logic [7:0]           accumulator_o, program_status_word_o, b_wdata_o;
  logic [15:0]          data_pointer_16_o;
  logic [4:0]           bank_base_o;
  int                   failures, samples_checked;
  logic [7:0]           adr [5];

  csr_core_regs csr_core_regs_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .bit_addr_i(bit_addr_i),
    .bit_rd_i(bit_rd_i), .bit_wr_i(bit_wr_i), .bit_wdata_i(bit_wdata_i), .push_i(push_i),
    .push_data_i(push_data_i), .pop_i(pop_i), .data_pointer_16_load_i(data_pointer_16_load_i),
    .data_pointer_16_wdata_i(data_pointer_16_wdata_i), .data_pointer_16_inc_i(data_pointer_16_inc_i), .acc_load_i(acc_load_i),
    .acc_wdata_i(acc_wdata_i), .alu_op_i(alu_op_i), .alu_operand_i(alu_operand_i),
    .b_reg_i(b_reg_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
    .bit_rdata_o(bit_rdata_o), .bit_hit_o(bit_hit_o), .stack_wr_o(stack_wr_o),
    .stack_rd_o(stack_rd_o), .stack_addr_o(stack_addr_o), .stack_wdata_o(stack_wdata_o),
    .data_pointer_16_o(data_pointer_16_o), .stack_top_pointer_o(stack_top_pointer_o),
    .accumulator_o(accumulator_o), .program_status_word_o(program_status_word_o),
    .bank_base_o(bank_base_o), .b_wr_o(b_wr_o), .b_wdata_o(b_wdata_o));

  // ********************************************************
  // Shared tasks
  // ********************************************************
  task automatic complete_run;
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Inputs move 1 ns after the edge so the design never races the bench
  task automatic cyc;
    @(posedge mclk_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr_i = a;
    sfr_wdata_i = v;
    sfr_wr_i = 1'b1;
    cyc;
    sfr_wr_i = 1'b0;
    // Idle edge so a following call never raises the strobe it just dropped
    cyc;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    cyc;
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
    h = sfr_hit_o;
    cyc;
  endtask : rd

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_reset;
    chk(stack_top_pointer_o, 24'h07);
    chk(accumulator_o, 24'h00);
    chk({data_pointer_16_o, program_status_word_o}, 24'h0);
  endtask : t_reset

  task automatic t_regs;
    adr = '{csr_pkg::ADDR_SP, csr_pkg::ADDR_DPL, csr_pkg::ADDR_DPH, csr_pkg::ADDR_PSW,
            csr_pkg::ADDR_ACC};
    foreach (adr[i]) wr(adr[i], 8'h5A);
    foreach (adr[i])
    begin
      rd(adr[i]);
      chk({h, d}, {1'b1, 8'h5A});
    end
    chk(data_pointer_16_o, 24'h5A5A);
    // A neighbour block owns this address, so this one must stay silent
    rd(8'hE1);
    chk({h, d}, 24'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr(csr_pkg::ADDR_PSW, {3'h0, k[1:0], 3'h0});
      chk(bank_base_o, {k[1:0], 3'h0});
    end
    wr(csr_pkg::ADDR_PSW, 8'hFF);
    chk(program_status_word_o, 24'hFE);
    bit_addr_i = 8'hE0;
    bit_wdata_i = 1'b1;
    bit_wr_i = 1'b1;
    cyc;
    bit_wr_i = 1'b0;
    chk({accumulator_o, program_status_word_o}, 24'h5BFF);
    bit_addr_i = 8'hD5;
    bit_rd_i = 1'b1;
    cyc;
    bit_rd_i = 1'b0;
    chk({bit_hit_o, bit_rdata_o}, 24'h3);
  endtask : t_regs

  // Starts below the top so the second push wraps the pointer
  task automatic t_stack;
    wr(csr_pkg::ADDR_SP, 8'hFE);
    push_data_i = 8'hAA;
    push_i = 1'b1;
    cyc;
    chk({stack_wr_o, stack_addr_o, stack_wdata_o}, {1'b1, 16'hFFAA});
    push_data_i = 8'h55;
    cyc;
    chk({stack_addr_o, stack_wdata_o, stack_top_pointer_o}, 24'h0055_00);
    push_i = 1'b0;
    pop_i = 1'b1;
    cyc;
    chk({stack_rd_o, stack_addr_o, stack_top_pointer_o}, {1'b1, 16'h00FF});
    // Pop stays up, so the next edge sees both and push must win
    push_i = 1'b1;
    cyc;
    push_i = 1'b0;
    pop_i = 1'b0;
    chk({stack_wr_o, stack_rd_o, stack_addr_o}, {2'h2, 8'h00});
  endtask : t_stack

  task automatic t_alu(input csr_pkg::csr_alu_op_e op, input logic [7:0] a,
    input logic [7:0] o, input logic [7:0] b, input logic c, input logic [7:0] ea,
    input logic [2:0] f, input logic [8:0] eb);
    acc_wdata_i = a;
    acc_load_i = 1'b1;
    wr(csr_pkg::ADDR_PSW, {c, 7'h22});
    acc_load_i = 1'b0;
    alu_op_i = op;
    alu_operand_i = o;
    b_reg_i = b;
    cyc;
    alu_op_i = csr_pkg::ALU_NONE;
    chk(accumulator_o, ea);
    chk(program_status_word_o, {f[2:1], 3'h4, f[0], 1'b1, ^ea});
    chk({b_wr_o, eb[8] ? b_wdata_o : 8'h00}, eb);
  endtask : t_alu

  task automatic t_data_pointer_16;
    data_pointer_16_wdata_i = 16'hFFFF;
    data_pointer_16_load_i = 1'b1;
    cyc;
    data_pointer_16_load_i = 1'b0;
    data_pointer_16_inc_i = 1'b1;
    cyc;
    data_pointer_16_inc_i = 1'b0;
    chk(data_pointer_16_o, 24'h0);
  endtask : t_data_pointer_16

  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  initial
  begin
    #1000000;
    failures++;
    complete_run;
  end

  initial
  begin
    {sys_rst_i, sfr_rd_i, sfr_wr_i, bit_rd_i, bit_wr_i, bit_wdata_i} = 6'h20;
    {push_i, pop_i, data_pointer_16_load_i, data_pointer_16_inc_i, acc_load_i} = 5'h00;
    {sfr_addr_i, sfr_wdata_i, bit_addr_i, push_data_i} = 32'h0;
    {acc_wdata_i, alu_operand_i, b_reg_i, data_pointer_16_wdata_i} = 40'h0;
    alu_op_i = csr_pkg::ALU_NONE;
    repeat (6) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset;
    t_regs;
    t_stack;
    t_alu(csr_pkg::ALU_ADD, 8'h7F, 8'h01, 8'h00, 1'b0, 8'h80, 3'h3, 9'h000);
    t_alu(csr_pkg::ALU_ADD, 8'hFF, 8'h01, 8'h00, 1'b1, 8'h00, 3'h6, 9'h000);
    t_alu(csr_pkg::ALU_ADD, 8'h88, 8'h88, 8'h00, 1'b0, 8'h10, 3'h7, 9'h000);
    t_alu(csr_pkg::ALU_ADD_CARRY, 8'h10, 8'h20, 8'h00, 1'b1, 8'h31, 3'h0, 9'h000);
    t_alu(csr_pkg::ALU_SUB_BORROW, 8'h00, 8'h01, 8'h00, 1'b0, 8'hFF, 3'h6, 9'h000);
    t_alu(csr_pkg::ALU_SUB_BORROW, 8'h80, 8'h00, 8'h00, 1'b1, 8'h7F, 3'h3, 9'h000);
    t_alu(csr_pkg::ALU_MUL, 8'h10, 8'h00, 8'h20, 1'b1, 8'h00, 3'h1, 9'h102);
    t_alu(csr_pkg::ALU_MUL, 8'h03, 8'h00, 8'h04, 1'b1, 8'h0C, 3'h0, 9'h100);
    t_alu(csr_pkg::ALU_DIV, 8'h07, 8'h00, 8'h00, 1'b1, 8'h07, 3'h1, 9'h000);
    t_alu(csr_pkg::ALU_DIV, 8'h07, 8'h00, 8'h02, 1'b1, 8'h03, 3'h0, 9'h101);
    t_data_pointer_16;
    complete_run;
  end
endmodule : csr_core_regs_tb

// ### core/csr_arith.sv
`timescale 1ns/1ps
module csr_arith (
  input  wire csr_pkg::csr_alu_op_e op_i,
  input  wire logic [7:0]           a_i,
  input  wire logic [7:0]           opnd_i,
  input  wire logic [7:0]           b_i,
  input  wire logic                 cy_i,
  output logic       [7:0]          res_o,
  output logic       [7:0]          b_res_o,
  output logic                      b_wr_o,
  output logic                      res_wr_o,
  output logic                      flag_wr_o,
  output logic                      cy_o,
  output logic                      ac_o,
  output logic                      ov_o
);

  logic [8:0]  sum9;
  logic [4:0]  nib5;
  logic [15:0] prod;
  logic        cin;

  always_comb
  begin
    cin = (op_i == csr_pkg::ALU_ADD) ? 1'b0 : cy_i;
    sum9 = 9'h000;
    nib5 = 5'h00;
    prod = 16'h0000;
    res_o = a_i;
    b_res_o = b_i;
    b_wr_o = 1'b0;
    res_wr_o = 1'b0;
    flag_wr_o = 1'b0;
    cy_o = 1'b0;
    ac_o = 1'b0;
    ov_o = 1'b0;
    unique case (op_i)
      csr_pkg::ALU_NONE: ;
      csr_pkg::ALU_ADD, csr_pkg::ALU_ADD_CARRY:
      begin
        sum9 = {1'b0, a_i} + {1'b0, opnd_i} + {8'h00, cin};
        nib5 = {1'b0, a_i[3:0]} + {1'b0, opnd_i[3:0]} + {4'h0, cin};
        res_o = sum9[7:0];
        res_wr_o = 1'b1;
        flag_wr_o = 1'b1;
        cy_o = sum9[8];
        ac_o = nib5[csr_pkg::NIB];
        ov_o = (a_i[7] == opnd_i[7]) && (sum9[7] != a_i[7]);
      end
      csr_pkg::ALU_SUB_BORROW:
      begin
        sum9 = {1'b0, a_i} - {1'b0, opnd_i} - {8'h00, cin};
        nib5 = {1'b0, a_i[3:0]} - {1'b0, opnd_i[3:0]} - {4'h0, cin};
        res_o = sum9[7:0];
        res_wr_o = 1'b1;
        flag_wr_o = 1'b1;
        cy_o = sum9[8];
        ac_o = nib5[csr_pkg::NIB];
        ov_o = (a_i[7] != opnd_i[7]) && (sum9[7] != a_i[7]);
      end
      csr_pkg::ALU_MUL:
      begin
        prod = a_i * b_i;
        res_o = prod[7:0];
        b_res_o = prod[15:8];
        b_wr_o = 1'b1;
        res_wr_o = 1'b1;
        flag_wr_o = 1'b1;
        ov_o = (prod[15:8] != 8'h00);
      end
      csr_pkg::ALU_DIV:
      begin
        flag_wr_o = 1'b1;
        // Divide by zero leaves both operands untouched
        if (b_i == 8'h00)
          ov_o = 1'b1;
        else
        begin
          res_o = a_i / b_i;
          b_res_o = a_i % b_i;
          b_wr_o = 1'b1;
          res_wr_o = 1'b1;
        end
      end
      default: ;
    endcase
  end

endmodule : csr_arith

// ### core/csr_core_regs.sv
// How it works
// - Push increments pointer, then stores at it
// - Stack pointer resets to 0x07
// - Data pointer bytes form one 16-bit address
// - Carry set on carry or borrow, else cleared
// - Nibble carry set on nibble carry or borrow
// - Status bits 4..3 select working register bank
// - Add/subtract signed overflow sets overflow flag
// - Multiply product above 255 sets overflow
// - Divide by zero sets overflow
// - Those instructions otherwise clear overflow
// - Parity bit read-only, odd parity of accumulator
// - User flags change only by software
// - Accumulator 8-bit, bit-addressable, resets to zero
// - All five registers reachable on every page
`timescale 1ns/1ps
module csr_core_regs (
  input  wire logic                 mclk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic [7:0]           sfr_addr_i,
  input  wire logic                 sfr_rd_i,
  input  wire logic                 sfr_wr_i,
  input  wire logic [7:0]           sfr_wdata_i,
  input  wire logic [7:0]           bit_addr_i,
  input  wire logic                 bit_rd_i,
  input  wire logic                 bit_wr_i,
  input  wire logic                 bit_wdata_i,
  input  wire logic                 push_i,
  input  wire logic [7:0]           push_data_i,
  input  wire logic                 pop_i,
  input  wire logic                 data_pointer_16_load_i,
  input  wire logic [15:0]          data_pointer_16_wdata_i,
  input  wire logic                 data_pointer_16_inc_i,
  input  wire logic                 acc_load_i,
  input  wire logic [7:0]           acc_wdata_i,
  input  wire csr_pkg::csr_alu_op_e alu_op_i,
  input  wire logic [7:0]           alu_operand_i,
  input  wire logic [7:0]           b_reg_i,
  output logic       [7:0]          sfr_rdata_o,
  output logic                      sfr_hit_o,
  output logic                      bit_rdata_o,
  output logic                      bit_hit_o,
  output logic                      stack_wr_o,
  output logic                      stack_rd_o,
  output logic       [7:0]          stack_addr_o,
  output logic       [7:0]          stack_wdata_o,
  output logic       [15:0]         data_pointer_16_o,
  output logic       [7:0]          stack_top_pointer_o,
  output logic       [7:0]          accumulator_o,
  output logic       [7:0]          program_status_word_o,
  output logic       [4:0]          bank_base_o,
  output logic                      b_wr_o,
  output logic       [7:0]          b_wdata_o
);

  // ********************************************************
  // Registers
  // ********************************************************
  logic [7:0] sp_r;
  logic [7:0] sp_nxt;
  logic [7:0] dpl_r;
  logic [7:0] dpl_nxt;
  logic [7:0] dph_r;
  logic [7:0] dph_nxt;
  logic [7:1] psw_r;
  logic [7:1] psw_nxt;
  logic       par_r;
  logic       par_nxt;
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic [4:0] bank_r;
  logic [7:0] psw_full;

  // Parity has no writable storage bit, so the full word is assembled here
  assign psw_full = {psw_r, par_r};

  // ********************************************************
  // Decode
  // ********************************************************
  // The page select never enters the decode: these five answer
  // on every page.
  logic hit_sp;
  logic hit_dpl;
  logic hit_dph;
  logic hit_psw;
  logic hit_acc;
  logic [7:0] bit_byte;
  logic [2:0] bit_idx;
  logic bhit_psw;
  logic bhit_acc;

  assign hit_sp   = (sfr_addr_i == csr_pkg::ADDR_SP);
  assign hit_dpl  = (sfr_addr_i == csr_pkg::ADDR_DPL);
  assign hit_dph  = (sfr_addr_i == csr_pkg::ADDR_DPH);
  assign hit_psw  = (sfr_addr_i == csr_pkg::ADDR_PSW);
  assign hit_acc  = (sfr_addr_i == csr_pkg::ADDR_ACC);
  assign bit_byte = {bit_addr_i[7:csr_pkg::BIT_LOG2], 3'b000};
  assign bit_idx  = bit_addr_i[csr_pkg::BIT_LOG2-1:0];
  assign bhit_psw = (bit_byte == csr_pkg::ADDR_PSW);
  assign bhit_acc = (bit_byte == csr_pkg::ADDR_ACC);

  // ********************************************************
  // Arithmetic
  // ********************************************************
  logic [7:0] alu_res;
  logic [7:0] alu_b;
  logic       alu_b_wr;
  logic       alu_res_wr;
  logic       alu_flag_wr;
  logic       alu_cy;
  logic       alu_ac;
  logic       alu_ov;
  logic       acc_odd;

  csr_arith csr_arith_inst (
    .op_i      (alu_op_i),
    .a_i       (acc_r),
    .opnd_i    (alu_operand_i),
    .b_i       (b_reg_i),
    .cy_i      (psw_r[csr_pkg::PSW_CARRY]),
    .res_o     (alu_res),
    .b_res_o   (alu_b),
    .b_wr_o    (alu_b_wr),
    .res_wr_o  (alu_res_wr),
    .flag_wr_o (alu_flag_wr),
    .cy_o      (alu_cy),
    .ac_o      (alu_ac),
    .ov_o      (alu_ov)
  );

  csr_parity #(
    .W (csr_pkg::DW)
  ) csr_parity_inst (
    .data_i (acc_nxt),
    .odd_o  (acc_odd)
  );

  // ********************************************************
  // Accumulator
  // ********************************************************
  // Later assignments win: an instruction result beats a
  // register write issued in the same cycle.
  always_comb
  begin
    acc_nxt = acc_r;
    if (sfr_wr_i && hit_acc)
      acc_nxt = sfr_wdata_i;
    if (bit_wr_i && bhit_acc)
      acc_nxt[bit_idx] = bit_wdata_i;
    if (acc_load_i)
      acc_nxt = acc_wdata_i;
    if (alu_res_wr)
      acc_nxt = alu_res;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      acc_r <= csr_pkg::RST_ACC;
    else
      acc_r <= acc_nxt;
  end

  // ********************************************************
  // Status word
  // ********************************************************
  always_comb
  begin
    psw_nxt = psw_r;
    if (sfr_wr_i && hit_psw)
      psw_nxt = sfr_wdata_i[7:1] & csr_pkg::PSW_WR_MASK[7:1];
    // Parity position has no storage, so bit writes there drop
    if (bit_wr_i && bhit_psw && (bit_idx != 3'(csr_pkg::PSW_PAR)))
      psw_nxt[bit_idx] = bit_wdata_i;
    if (alu_flag_wr)
    begin
      psw_nxt[csr_pkg::PSW_CARRY] = alu_cy;
      psw_nxt[csr_pkg::PSW_NIBC]  = alu_ac;
      psw_nxt[csr_pkg::PSW_OVF]   = alu_ov;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      psw_r <= csr_pkg::RST_PSW[7:1];
    else
      psw_r <= psw_nxt;
  end

  // Tracks the accumulator's next value so it never lags
  assign par_nxt = acc_odd;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      par_r <= 1'b0;
    else
      par_r <= par_nxt;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      bank_r <= 5'h00;
    else
      bank_r <= {psw_nxt[csr_pkg::PSW_RSH:csr_pkg::PSW_RSL],
                 3'b000};
  end

  // ********************************************************
  // Stack pointer
  // ********************************************************
  // Push takes priority if both arrive together.
  always_comb
  begin
    sp_nxt = sp_r;
    if (sfr_wr_i && hit_sp)
      sp_nxt = sfr_wdata_i;
    if (push_i)
      sp_nxt = sp_r + 8'h01;
    else if (pop_i)
      sp_nxt = sp_r - 8'h01;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sp_r <= csr_pkg::RST_SP;
    else
      sp_r <= sp_nxt;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stack_wr_o    <= 1'b0;
      stack_rd_o    <= 1'b0;
      stack_addr_o  <= 8'h00;
      stack_wdata_o <= 8'h00;
    end
    else
    begin
      stack_wr_o <= push_i;
      stack_rd_o <= pop_i && !push_i;
      if (push_i)
      begin
        stack_addr_o  <= sp_r + 8'h01;
        stack_wdata_o <= push_data_i;
      end
      else if (pop_i)
        stack_addr_o <= sp_r;
    end
  end

  // ********************************************************
  // Data pointer
  // ********************************************************
  always_comb
  begin
    dpl_nxt = dpl_r;
    dph_nxt = dph_r;
    if (sfr_wr_i && hit_dpl)
      dpl_nxt = sfr_wdata_i;
    if (sfr_wr_i && hit_dph)
      dph_nxt = sfr_wdata_i;
    if (data_pointer_16_load_i)
      {dph_nxt, dpl_nxt} = data_pointer_16_wdata_i;
    else if (data_pointer_16_inc_i)
      {dph_nxt, dpl_nxt} = {dph_r, dpl_r} + 16'h0001;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      dpl_r <= csr_pkg::RST_DPL;
      dph_r <= csr_pkg::RST_DPH;
    end
    else
    begin
      dpl_r <= dpl_nxt;
      dph_r <= dph_nxt;
    end
  end

  // ********************************************************
  // Second operand write-back
  // ********************************************************
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      b_wr_o    <= 1'b0;
      b_wdata_o <= 8'h00;
    end
    else
    begin
      b_wr_o <= alu_b_wr;
      if (alu_b_wr)
        b_wdata_o <= alu_b;
    end
  end

  // ********************************************************
  // Read ports
  // ********************************************************
  // Reads see the value held before the edge; unmapped
  // addresses answer zero with the hit flag low.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sfr_rdata_o <= 8'h00;
      sfr_hit_o   <= 1'b0;
    end
    else if (sfr_rd_i)
    begin
      sfr_hit_o <= hit_sp | hit_dpl | hit_dph | hit_psw | hit_acc;
      if (hit_sp)
        sfr_rdata_o <= sp_r;
      else if (hit_dpl)
        sfr_rdata_o <= dpl_r;
      else if (hit_dph)
        sfr_rdata_o <= dph_r;
      else if (hit_psw)
        sfr_rdata_o <= psw_full;
      else if (hit_acc)
        sfr_rdata_o <= acc_r;
      else
        sfr_rdata_o <= 8'h00;
    end
    else
    begin
      sfr_rdata_o <= 8'h00;
      sfr_hit_o   <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bit_rdata_o <= 1'b0;
      bit_hit_o   <= 1'b0;
    end
    else
    begin
      bit_hit_o <= bit_rd_i && (bhit_psw || bhit_acc);
      if (bit_rd_i && bhit_psw)
        bit_rdata_o <= psw_full[bit_idx];
      else if (bit_rd_i && bhit_acc)
        bit_rdata_o <= acc_r[bit_idx];
      else
        bit_rdata_o <= 1'b0;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign data_pointer_16_o     = {dph_r, dpl_r};
  assign stack_top_pointer_o   = sp_r;
  assign accumulator_o         = acc_r;
  assign program_status_word_o = psw_full;
  assign bank_base_o           = bank_r;

endmodule : csr_core_regs

// ### core/csr_parity.sv
`timescale 1ns/1ps
module csr_parity #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] data_i,
  output logic              odd_o
);

  // Odd count of ones gives 1
  assign odd_o = ^data_i;

endmodule : csr_parity

// ### core/csr_pkg.sv
package csr_pkg;

  // ********************************************************
  // Widths
  // ********************************************************
  localparam int DW        = 8;
  localparam int PW        = 16;
  localparam int NIB       = 4;
  localparam int BANK_LOG2 = 3;
  localparam int BIT_LOG2  = 3;

  // ********************************************************
  // Register addresses in the special function space
  // ********************************************************
  localparam logic [7:0] ADDR_SP  = 8'h81;
  localparam logic [7:0] ADDR_DPL = 8'h82;
  localparam logic [7:0] ADDR_DPH = 8'h83;
  localparam logic [7:0] ADDR_PSW = 8'hD0;
  localparam logic [7:0] ADDR_ACC = 8'hE0;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [7:0] RST_SP  = 8'h07;
  localparam logic [7:0] RST_DPL = 8'h00;
  localparam logic [7:0] RST_DPH = 8'h00;
  localparam logic [7:0] RST_PSW = 8'h00;
  localparam logic [7:0] RST_ACC = 8'h00;

  // ********************************************************
  // Status word fields
  // ********************************************************
  localparam int PSW_CARRY = 7;
  localparam int PSW_NIBC  = 6;
  localparam int PSW_UFA   = 5;
  localparam int PSW_RSH   = 4;
  localparam int PSW_RSL   = 3;
  localparam int PSW_OVF   = 2;
  localparam int PSW_UFB   = 1;
  localparam int PSW_PAR   = 0;
  localparam logic [7:0] PSW_WR_MASK = 8'hFE;
  localparam logic [7:0] BYTE_MAX    = 8'hFF;

  // ********************************************************
  // Arithmetic operations, one-hot
  // ********************************************************
  typedef enum logic [5:0] {
    ALU_NONE = 6'h01,
    ALU_ADD  = 6'h02,
    ALU_ADD_CARRY  = 6'h04,
    ALU_SUB_BORROW = 6'h08,
    ALU_MUL  = 6'h10,
    ALU_DIV  = 6'h20
  } csr_alu_op_e;

endpackage : csr_pkg
